// ==== design/spicc_top.sv ====
// Serial peripheral block: control registers, pin routing and byte shifter
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - Receive enable requests interrupt while receive-full or fault flag is set.
// - Clearing enable aborts any transfer and resets the state machine.
// - While disabled, receive-full is clear and transmit-empty is set.
// - Transmit enable requests interrupt while transmit-empty is set.
// - Master select: 0 slave, 1 master.
// - Polarity 0 idles clock low, 1 idles clock high.
// - Phase 0 first edge mid first bit, 1 at its start.
// - Bit order 0 sends MSB first, 1 sends LSB first.
// - Master with fault detect off leaves the select pin untouched.
// - Master with fault detect on: select is fault input or automatic output.
// - Slave mode: select pin is always the select input.
// - Single-wire mode: drive enable makes the shared pin input or output.
// - Wait stop halts the shifter while the processor waits.
// - Single-wire uses slave data pin as slave, master data pin as master.
// - Control two bits 7, 6, 5 and 2 read as zero.
// - While disabled, all four pins are released to general I/O.
// - Receive-full sets at transfer end; transmit-empty sets when buffer frees.
module spicc_top #(
   parameter int HALF_BIT = spicc_pkg::HALF_BIT_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Processor state and interrupt request
   input wire logic wait_mode,
   output logic irq,
   // Serial clock pin
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   // Master data out pin, shared pin in master single-wire mode
   input wire logic master_shared_data_pin_in,
   output logic master_shared_data_pin_out,
   output logic master_shared_data_pin_oe,
   // Slave data out pin, shared pin in slave single-wire mode
   input wire logic slave_shared_data_pin_in,
   output logic slave_shared_data_pin_out,
   output logic slave_shared_data_pin_oe,
   // Slave select pin
   input wire logic select_pin_in,
   output logic select_pin_out,
   output logic select_pin_oe
);

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic rx_fault_irq_enable;
   logic system_enable_bit;
   logic tx_empty_irq_enable;
   logic master_select;
   logic clock_polarity;
   logic clock_phase;
   logic select_output_enable;
   logic low_bit_first;
   logic fault_detect_enable;
   logic single_wire_drive_enable;
   logic wait_clock_stop;
   logic single_wire_select;

   // ------------------------------------------------------------
   // Status and data path
   // ------------------------------------------------------------
   logic receive_full_flag;
   logic fault_flag;
   logic tx_full;
   logic [7:0] tx_buf;
   logic [7:0] rx_buf;
   logic [7:0] tx_sh;
   logic [7:0] rx_sh;
   logic [3:0] edge_idx;
   logic sck_int;
   logic sck_prev;
   spicc_pkg::spicc_state_type state;

   logic transmit_empty_flag;
   logic [3:0] pins_s;
   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic sel_s;
   logic run;
   logic div_tick;
   logic slave_tick;
   logic edge_go;
   logic sample_edge;
   logic last_edge;
   logic din;
   logic tx_bit;
   logic master_start;
   logic slave_load;
   logic fault_sense;
   logic wr_c1;
   logic wr_c2;
   logic wr_data;
   logic rd_data;
   logic [7:0] next_rx;
   logic [7:0] next_tx;

   // Disabled block shows an empty buffer at once, not a cycle after the write
   assign transmit_empty_flag = !tx_full || !system_enable_bit;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   spicc_sync #(
      .W(4)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in({serial_clock_pin_in, master_shared_data_pin_in,
                 slave_shared_data_pin_in, select_pin_in}),
      .sync_out(pins_s)
   );

   assign sck_s = pins_s[3];
   assign mosi_s = pins_s[2];
   assign miso_s = pins_s[1];
   assign sel_s = pins_s[0];

   // ------------------------------------------------------------
   // Enables and decodes
   // ------------------------------------------------------------
   // Wait stop freezes the shifter only; the register port stays live
   assign run = system_enable_bit && !(wait_clock_stop && wait_mode);

   spicc_divider #(
      .CYCLES(HALF_BIT)
   ) u_div (
      .clk(clk),
      .rstn(rstn),
      .run(run && master_select && state == spicc_pkg::ST_XFER),
      .tick(div_tick)
   );

   assign wr_c1 = reg_wr && reg_addr == spicc_pkg::ADDR_CTRL_ONE;
   assign wr_c2 = reg_wr && reg_addr == spicc_pkg::ADDR_CTRL_TWO;
   assign wr_data = reg_wr && reg_addr == spicc_pkg::ADDR_DATA;
   assign rd_data = reg_rd && reg_addr == spicc_pkg::ADDR_DATA;

   // Slave shifts only on clock edges seen while select is held low
   assign slave_tick = !master_select && !sel_s && (sck_s != sck_prev);

   assign edge_go = run && (master_select ? (state == spicc_pkg::ST_XFER && div_tick)
                                          : slave_tick);
   // Phase 0 samples on even edges, phase 1 on odd edges
   assign sample_edge = edge_idx[0] == clock_phase;
   assign last_edge = edge_idx == spicc_pkg::LAST_EDGE;

   // Receive pin choice by mode and wire count
   always_comb begin
      if (master_select) begin
         din = single_wire_select ? mosi_s : miso_s;
      end else begin
         din = single_wire_select ? miso_s : mosi_s;
      end
   end

   assign tx_bit = low_bit_first ? tx_sh[0] : tx_sh[7];
   assign next_rx = low_bit_first ? {din, rx_sh[7:1]} : {rx_sh[6:0], din};
   assign next_tx = low_bit_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};

   assign master_start = run && master_select && state == spicc_pkg::ST_IDLE && tx_full;
   assign slave_load = run && !master_select && state == spicc_pkg::ST_IDLE
                       && tx_full && !edge_go;

   // Another master pulling select low while fault detect input is active
   assign fault_sense = system_enable_bit && master_select && fault_detect_enable
                        && !select_output_enable && !sel_s;

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {rx_fault_irq_enable, system_enable_bit, tx_empty_irq_enable, master_select,
          clock_polarity, clock_phase, select_output_enable, low_bit_first}
            <= spicc_pkg::CTRL_ONE_RESET;
      end else if (wr_c1) begin
         rx_fault_irq_enable <= reg_wdata[spicc_pkg::C1_RX_IRQ_EN];
         system_enable_bit <= reg_wdata[spicc_pkg::C1_ENABLE];
         tx_empty_irq_enable <= reg_wdata[spicc_pkg::C1_TX_IRQ_EN];
         master_select <= reg_wdata[spicc_pkg::C1_MASTER];
         clock_polarity <= reg_wdata[spicc_pkg::C1_POLARITY];
         clock_phase <= reg_wdata[spicc_pkg::C1_PHASE];
         select_output_enable <= reg_wdata[spicc_pkg::C1_SEL_OUT_EN];
         low_bit_first <= reg_wdata[spicc_pkg::C1_LOW_FIRST];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_detect_enable <= spicc_pkg::CTRL_TWO_RESET[spicc_pkg::C2_FAULT_EN];
         single_wire_drive_enable <= spicc_pkg::CTRL_TWO_RESET[spicc_pkg::C2_DRIVE_EN];
         wait_clock_stop <= spicc_pkg::CTRL_TWO_RESET[spicc_pkg::C2_WAIT_STOP];
         single_wire_select <= spicc_pkg::CTRL_TWO_RESET[spicc_pkg::C2_SINGLE_WIRE];
      end else if (wr_c2) begin
         fault_detect_enable <= reg_wdata[spicc_pkg::C2_FAULT_EN];
         single_wire_drive_enable <= reg_wdata[spicc_pkg::C2_DRIVE_EN];
         wait_clock_stop <= reg_wdata[spicc_pkg::C2_WAIT_STOP];
         single_wire_select <= reg_wdata[spicc_pkg::C2_SINGLE_WIRE];
      end
   end

   // ------------------------------------------------------------
   // Register reads, one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            spicc_pkg::ADDR_CTRL_ONE: begin
               reg_rdata <= {rx_fault_irq_enable, system_enable_bit, tx_empty_irq_enable,
                             master_select, clock_polarity, clock_phase,
                             select_output_enable, low_bit_first};
            end
            spicc_pkg::ADDR_CTRL_TWO: begin
               reg_rdata <= {3'h0, fault_detect_enable, single_wire_drive_enable, 1'b0,
                             wait_clock_stop, single_wire_select};
            end
            spicc_pkg::ADDR_STATUS: begin
               reg_rdata <= {receive_full_flag, 1'b0, transmit_empty_flag, fault_flag, 4'h0};
            end
            spicc_pkg::ADDR_DATA: begin
               reg_rdata <= rx_buf;
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Transmit buffer
   // ------------------------------------------------------------
   // A write while the buffer is still full is dropped, never overwrites
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_full <= 1'b0;
         tx_buf <= 8'h00;
      end else if (!system_enable_bit) begin
         tx_full <= 1'b0;
      end else if (master_start || slave_load) begin
         tx_full <= 1'b0;
      end else if (wr_data && !tx_full) begin
         tx_full <= 1'b1;
         tx_buf <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // Receive flag and buffer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         receive_full_flag <= 1'b0;
         rx_buf <= 8'h00;
      end else if (!system_enable_bit) begin
         receive_full_flag <= 1'b0;
      end else if (edge_go && last_edge) begin
         receive_full_flag <= 1'b1;
         rx_buf <= sample_edge ? next_rx : rx_sh;
      end else if (rd_data) begin
         receive_full_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Fault flag
   // ------------------------------------------------------------
   // Set wins over the clearing write to control one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_flag <= 1'b0;
      end else if (fault_sense) begin
         fault_flag <= 1'b1;
      end else if (wr_c1) begin
         fault_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Transfer state machine and shifters
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= spicc_pkg::ST_IDLE;
         edge_idx <= 4'h0;
      end else if (!system_enable_bit || fault_sense) begin
         state <= spicc_pkg::ST_IDLE;
         edge_idx <= 4'h0;
      end else if (!master_select && sel_s) begin
         state <= spicc_pkg::ST_IDLE;
         edge_idx <= 4'h0;
      end else begin
         case (state)
            spicc_pkg::ST_IDLE: begin
               if (master_start) begin
                  state <= spicc_pkg::ST_XFER;
               end else if (edge_go) begin
                  state <= spicc_pkg::ST_XFER;
                  edge_idx <= 4'h1;
               end
            end
            spicc_pkg::ST_XFER: begin
               if (edge_go) begin
                  edge_idx <= edge_idx + 4'h1;
                  if (last_edge) begin
                     state <= spicc_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               state <= spicc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_sh <= 8'h00;
         rx_sh <= 8'h00;
      end else if (master_start || slave_load) begin
         tx_sh <= tx_buf;
      end else if (edge_go) begin
         if (sample_edge) begin
            rx_sh <= next_rx;
         end else if (edge_idx != 4'h0) begin
            tx_sh <= next_tx;
         end
      end
   end

   // Master serial clock toggles on every half-bit edge from its idle level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_int <= 1'b0;
      end else if (state == spicc_pkg::ST_IDLE) begin
         sck_int <= clock_polarity;
      end else if (edge_go && master_select) begin
         sck_int <= !sck_int;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_prev <= 1'b0;
      end else begin
         sck_prev <= sck_s;
      end
   end

   // ------------------------------------------------------------
   // Interrupt request
   // ------------------------------------------------------------
   assign irq = (rx_fault_irq_enable && (receive_full_flag || fault_flag))
                || (tx_empty_irq_enable && transmit_empty_flag);

   // ------------------------------------------------------------
   // Pin routing
   // ------------------------------------------------------------
   // Disabled block releases every pin to general I/O
   always_comb begin
      serial_clock_pin_out = sck_int;
      serial_clock_pin_oe = 1'b0;
      master_shared_data_pin_out = tx_bit;
      master_shared_data_pin_oe = 1'b0;
      slave_shared_data_pin_out = tx_bit;
      slave_shared_data_pin_oe = 1'b0;
      select_pin_out = 1'b0;
      select_pin_oe = 1'b0;
      if (system_enable_bit) begin
         if (master_select) begin
            serial_clock_pin_oe = 1'b1;
            master_shared_data_pin_oe = !single_wire_select
                                        || single_wire_drive_enable;
            // Select driven low only for the length of a transfer
            select_pin_out = state != spicc_pkg::ST_XFER;
            select_pin_oe = fault_detect_enable && select_output_enable;
         end else begin
            // Slave drives only while selected, so shared lines stay free
            slave_shared_data_pin_oe = !sel_s && (!single_wire_select
                                       || single_wire_drive_enable);
         end
      end
   end

endmodule : spicc_top

// ==== design/spicc_pkg.sv ====
// Shared constants and types of the serial control and configuration block
package spicc_pkg;

   // ------------------------------------------------------------
   // Register indices on the plain register port
   // ------------------------------------------------------------
   localparam logic [1:0] ADDR_CTRL_ONE = 2'h0;
   localparam logic [1:0] ADDR_CTRL_TWO = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   localparam logic [1:0] ADDR_DATA = 2'h3;

   // ------------------------------------------------------------
   // Control one fields
   // ------------------------------------------------------------
   localparam int C1_RX_IRQ_EN = 7;
   localparam int C1_ENABLE = 6;
   localparam int C1_TX_IRQ_EN = 5;
   localparam int C1_MASTER = 4;
   localparam int C1_POLARITY = 3;
   localparam int C1_PHASE = 2;
   localparam int C1_SEL_OUT_EN = 1;
   localparam int C1_LOW_FIRST = 0;

   // ------------------------------------------------------------
   // Control two fields
   // ------------------------------------------------------------
   localparam int C2_FAULT_EN = 4;
   localparam int C2_DRIVE_EN = 3;
   localparam int C2_WAIT_STOP = 1;
   localparam int C2_SINGLE_WIRE = 0;

   // ------------------------------------------------------------
   // Status fields
   // ------------------------------------------------------------
   localparam int ST_RX_FULL = 7;
   localparam int ST_TX_EMPTY = 5;
   localparam int ST_FAULT = 4;

   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
   localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
   localparam int CLK_PERIOD_NS = 100;
   localparam int HALF_BIT_NS = 400;
   localparam int HALF_BIT_CYCLES = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] LAST_EDGE = 4'hf;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_XFER = 1'b1
   } spicc_state_type;

endpackage : spicc_pkg

// ==== design/spicc_sync.sv ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module spicc_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Pins in, synchronised levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : spicc_sync

// ==== design/spicc_divider.sv ====
// Half-bit tick divider for master mode
`timescale 1ns/1ps
module spicc_divider #(
   parameter int CYCLES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control and tick
   input wire logic run,
   output logic tick
);

   logic [15:0] count;

   // Restarts whenever run drops, so every transfer begins with a full half bit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (!run) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (count == 16'(CYCLES - 1)) begin
         count <= 16'h0000;
         tick <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick <= 1'b0;
      end
   end

endmodule : spicc_divider

// ==== verif/spicc_monitor.sv ====
// Port-level checker for the serial control block
`timescale 1ns/1ps
module spicc_monitor (
   // Clock, reset and register port
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Interrupt and pin drives
   input wire logic irq,
   input wire logic serial_clock_pin_out,
   input wire logic serial_clock_pin_oe,
   input wire logic master_shared_data_pin_oe,
   input wire logic slave_shared_data_pin_oe,
   input wire logic select_pin_oe
);
   // ---------------------------------------------
   // Shadow control registers, seen from the port
   // ---------------------------------------------
   logic [7:0] c1;
   logic [7:0] c2;
   logic en;
   logic ms;
   assign en = c1[6];
   assign ms = en && c1[4];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) c1 <= 8'h00;
      else if (reg_wr && reg_addr == 2'h0) c1 <= reg_wdata;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) c2 <= 8'h00;
      else if (reg_wr && reg_addr == 2'h1) c2 <= reg_wdata;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence dis_wr;
      reg_wr && reg_addr == 2'h0 && !reg_wdata[6];
   endsequence
   sequence mst_on;
      reg_wr && reg_addr == 2'h0 && reg_wdata[6] && reg_wdata[4];
   endsequence
   sequence c2_rd;
      reg_rd && reg_addr == 2'h1;
   endsequence
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   pins_free_a: assert property (!en |-> !(serial_clock_pin_oe || select_pin_oe
      || master_shared_data_pin_oe || slave_shared_data_pin_oe)) else $error("pin driven");
   abort_now_a: assert property (dis_wr |=> (!serial_clock_pin_oe && !select_pin_oe) [*2])
      else $error("transfer not stopped");
   gpio_sel_a: assert property (ms && !c2[4] |-> !select_pin_oe)
      else $error("select driven as gpio");
   fault_in_a: assert property (ms && c2[4] && !c1[1] |-> !select_pin_oe)
      else $error("fault input driven");
   auto_sel_a: assert property (ms && c2[4] && c1[1] |-> select_pin_oe)
      else $error("select output not driven");
   slave_pins_a: assert property (en && !c1[4] |-> !select_pin_oe && !serial_clock_pin_oe)
      else $error("slave drives select or clock");
   clk_drive_a: assert property (ms |-> serial_clock_pin_oe)
      else $error("master clock not driven");
   clk_idle_a: assert property (mst_on |-> ##2 (serial_clock_pin_out == c1[3]) [*2])
      else $error("clock idle level wrong");
   one_wire_a: assert property (en && c2[0] && !c2[3] |-> !master_shared_data_pin_oe
      && !slave_shared_data_pin_oe) else $error("single wire pin driven");
   unused_pin_a: assert property (ms && c2[0] |-> !slave_shared_data_pin_oe)
      else $error("unused data pin driven");
   rsvd_zero_a: assert property (c2_rd |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[2])
      else $error("reserved bits set");
   irq_quiet_a: assert property (!c1[7] && !c1[5] |-> !irq)
      else $error("interrupt while inhibited");
   tx_irq_a: assert property (!en && c1[5] |-> irq)
      else $error("transmit empty interrupt missing");
endmodule : spicc_monitor
bind spicc_top spicc_monitor spicc_monitor_i (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .irq, .serial_clock_pin_out, .serial_clock_pin_oe,
   .master_shared_data_pin_oe, .slave_shared_data_pin_oe, .select_pin_oe);

// ==== verif/spicc_partner.sv ====
// External serial master model for slave-mode traffic
`timescale 1ns/1ps
module spicc_partner (
   // Link pins
   output logic sck,
   output logic ss_n,
   output logic mosi,
   input wire logic miso
);
   logic [7:0] got;
   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
      got = 8'h00;
   end
   // Clock stands still outside a frame; 800 ns bit period
   task automatic frame(input logic [7:0] d, input logic pol, input logic pha, input logic lsb);
      // Idle level settles long before select falls, so no false edge is seen
      #7 sck = pol;
      #450 ss_n = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (pha) sck = ~pol;
         mosi = lsb ? d[i] : d[7-i];
         #400 sck = pha ? pol : ~pol;
         got = lsb ? {miso, got[7:1]} : {got[6:0], miso};
         #400 sck = pol;
      end
      #400 ss_n = 1'b1;
      // Released line must not keep showing the last bit
      mosi = ~mosi;
   endtask : frame
endmodule : spicc_partner

// ==== verif/test_spicc_top.sv ====
// Self-checking bench for the serial control block
`timescale 1ns/1ps
module test_spicc_top;
   logic clk, rstn, reg_wr, reg_rd, wait_mode, ss_low, rd_pend;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, t, r;
   logic irq, sck_o, sck_oe, m_o, m_oe, s_o, s_oe, sel_o, sel_oe, p_sck, p_ss, p_mosi;
   logic [7:0] exp_q[$];
   int n_errors, comparisons, cyc;
   // Wire levels from every party's drive
   wire sck_w = sck_oe ? sck_o : p_sck;
   wire sel_w = sel_oe ? sel_o : (p_ss & ~ss_low);
   wire m_w = m_oe ? m_o : p_mosi;
   // Master data loops back into its own input, so the shifted byte is checked
   wire s_w = s_oe ? s_o : m_w;
   spicc_top #(.HALF_BIT(4)) spicc_top_i (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .wait_mode, .irq, .serial_clock_pin_in(sck_w),
      .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
      .master_shared_data_pin_in(m_w), .master_shared_data_pin_out(m_o),
      .master_shared_data_pin_oe(m_oe), .slave_shared_data_pin_in(s_w),
      .slave_shared_data_pin_out(s_o), .slave_shared_data_pin_oe(s_oe),
      .select_pin_in(sel_w), .select_pin_out(sel_o), .select_pin_oe(sel_oe));
   spicc_partner spicc_partner_i (.sck(p_sck), .ss_n(p_ss), .mosi(p_mosi), .miso(s_w));
   initial clk = 1'b0;
   always #50 clk = ~clk;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic close_out;
      $display("Errors %0d of %0d comparisons", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   // Strobes drop with a one-cycle gap so no signal is driven twice in a step
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : rd
   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_pend) chk(reg_rdata, exp_q.pop_front());
      rd_pend <= reg_rd;
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end
   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      wait_mode = 1'b0;
      ss_low = 1'b0;
      rd_pend = 1'b0;
      void'($urandom(20));
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h20);
      wr(2'h2, 8'hff);
      rd(2'h2, 8'h20);
      wr(2'h1, 8'hff);
      rd(2'h1, 8'h1b);
      wr(2'h0, 8'h20);
      chk({7'h0, irq}, 8'h01);
      wr(2'h0, 8'h80);
      chk({7'h0, irq}, 8'h00);
      wr(2'h1, 8'h00);
      for (int m = 0; m < 8; m++) begin
         t = 8'($urandom);
         r = 8'($urandom);
         wr(2'h0, {4'hc, m[2], m[1], 1'b0, m[0]});
         wr(2'h3, t);
         spicc_partner_i.frame(r, m[2], m[1], m[0]);
         repeat (4) @(posedge clk);
         chk({7'h0, irq}, 8'h01);
         rd(2'h2, 8'ha0);
         rd(2'h3, r);
         chk({7'h0, irq}, 8'h00);
         chk(spicc_partner_i.got, t);
      end
      wr(2'h1, 8'h10);
      wr(2'h0, 8'h5a);
      @(posedge clk);
      chk({7'h0, sck_o, sck_oe, sel_oe}, 8'h07);
      wr(2'h3, 8'h96);
      repeat (6) @(posedge clk);
      chk({7'h0, sel_o}, 8'h00);
      repeat (70) @(posedge clk);
      rd(2'h2, 8'ha0);
      rd(2'h3, 8'h96);
      wr(2'h1, 8'h12);
      wr(2'h3, 8'h69);
      repeat (6) @(posedge clk);
      wait_mode <= 1'b1;
      repeat (50) @(posedge clk);
      rd(2'h2, 8'h20);
      wait_mode <= 1'b0;
      repeat (70) @(posedge clk);
      rd(2'h2, 8'ha0);
      rd(2'h3, 8'h69);
      wr(2'h3, 8'h3c);
      repeat (10) @(posedge clk);
      wr(2'h0, 8'h1a);
      chk({4'h0, sck_oe, m_oe, s_oe, sel_oe}, 8'h00);
      rd(2'h2, 8'h20);
      wr(2'h0, 8'h5a);
      repeat (40) @(posedge clk);
      rd(2'h2, 8'h20);
      wr(2'h0, 8'hd0);
      ss_low <= 1'b1;
      repeat (4) @(posedge clk);
      rd(2'h2, 8'h30);
      chk({7'h0, irq}, 8'h01);
      ss_low <= 1'b0;
      // Let the released select pass the pin synchroniser before clearing the fault
      repeat (3) @(posedge clk);
      wr(2'h0, 8'h50);
      rd(2'h2, 8'h20);
      wr(2'h1, 8'h19);
      chk({6'h0, m_oe, s_oe}, 8'h02);
      wr(2'h1, 8'h11);
      chk({6'h0, m_oe, s_oe}, 8'h00);
      repeat (2) @(posedge clk);
      close_out();
   end
endmodule : test_spicc_top
